//--- logic/emb_pkg.sv
// constants, field layouts and types for the external memory bus sequencer
package emb_pkg;

    // ----------------------------------------------------------------
    // register map: word indexes, byte address is four times the index
    // ----------------------------------------------------------------
    localparam logic [7:0] CSC_IDX = 8'h8e;
    localparam logic [7:0] BUS_CFG_IDX = 8'h90;
    localparam logic [7:0] STATUS_IDX = 8'h91;
    localparam logic [1:0] ADR_TOP_ZERO = 2'h0;

    // ----------------------------------------------------------------
    // clock_and_stretch_control fields
    // ----------------------------------------------------------------
    localparam int STRETCH_LSB = 0;
    localparam int MULT_BIT = 3;
    localparam int DIV_LSB = 6;
    localparam logic [7:0] CSC_RESET = 8'h81;

    // ----------------------------------------------------------------
    // bus_config fields
    // ----------------------------------------------------------------
    localparam int PAGE_EN_BIT = 0;
    localparam int PAGE_SEL_LSB = 1;
    localparam int ALE_INT_BIT = 3;
    localparam logic [3:0] BUS_CFG_RESET = 4'h0;

    // ----------------------------------------------------------------
    // status fields
    // ----------------------------------------------------------------
    localparam int ST_STRETCH_LSB = 0;
    localparam int ST_BUSY_BIT = 4;
    localparam int ST_MISS_BIT = 5;
    localparam int ST_VALID_BIT = 6;
    localparam int ST_HI_LSB = 8;

    // ----------------------------------------------------------------
    // clock divider codes and rates
    // ----------------------------------------------------------------
    localparam logic [1:0] DIV_ONE = 2'h2;
    localparam logic [1:0] DIV_SLOW = 2'h3;
    localparam logic [9:0] SLOW_DIV_LAST = 10'h3ff;

    // ----------------------------------------------------------------
    // access kinds and page mode selects
    // ----------------------------------------------------------------
    localparam logic [1:0] KIND_CODE = 2'h0;
    localparam logic [1:0] KIND_RD = 2'h1;
    localparam logic [1:0] KIND_WR = 2'h2;
    localparam logic [1:0] PAGE_SEL_ALT = 2'h3;

    // ----------------------------------------------------------------
    // cycle lengths and strobe positions in system clocks, slow stretch limits in stretch cycles
    // ----------------------------------------------------------------
    localparam logic [6:0] INT_CLKS = 7'h01;
    localparam logic [6:0] CODE_CLKS = 7'h04;
    localparam logic [6:0] CODE_STRB_START = 7'h02;
    localparam logic [6:0] DATA_CLKS = 7'h08;
    localparam logic [6:0] ALE_CLKS = 7'h01;
    localparam logic [6:0] ALE_SLOW_CLKS = 7'h05;
    localparam logic [6:0] STRB0_START = 7'h04;
    localparam logic [6:0] STRB0_END = 7'h06;
    localparam logic [6:0] STRB1_START = 7'h05;
    localparam logic [6:0] STRB4_START = 7'h0d;
    localparam logic [3:0] SLOW_STRETCH_BASE = 4'h3;
    localparam logic [3:0] FIRST_SLOW_STRETCH = 4'h7;

    typedef enum logic {EMB_IDLE, EMB_RUN} emb_state_e;

endpackage

//--- logic/emb_tick_if.sv
// carrier between the sequencer and its system clock divider
`timescale 1ns/1ps
interface emb_tick_if;
    logic [1:0] div_sel;
    logic tick;
    modport gen (input div_sel, output tick);
    modport use_side (output div_sel, input tick);
endinterface

//--- logic/emb_tick_div.sv
// system clock enable divider driven from the oscillator clock
`timescale 1ns/1ps
module emb_tick_div (
    input wire logic clk_i,
    input wire logic rst_b_i,
    emb_tick_if.gen tk
);

    typedef struct packed {
        logic [9:0] cnt;
        logic tick;
    } emb_div_s;

    emb_div_s r;
    emb_div_s n;

    // divide-by-one ticks every clock; the slow mode once per 1024
    always_comb
    begin
        n = r;
        if (tk.div_sel == emb_pkg::DIV_SLOW)
        begin
            n.tick = (r.cnt == emb_pkg::SLOW_DIV_LAST);
            n.cnt = r.cnt + 10'h001;
        end
        else
        begin
            n.tick = 1'b1;
            n.cnt = 10'h000;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            r <= '0;
        else
            r <= n;
    end

    assign tk.tick = r.tick;

endmodule

//--- logic/emb_sequencer.sv
// external memory bus sequencer with data-cycle stretch and wishbone registers
`timescale 1ns/1ps
// Behaviour
// - external code fetch 4 clocks, internal 1
// - external data basic cycle 4, internal 1
// - page cycles 1/2/4 hit, 2/4/8 miss
// - alternate page bus speeds code only
// - latch strobe off internally unless option set
// - latch strobe on external code fetch except page hits
// - code strobe low only on external fetch
// - stretch in control bits 2..0, rewritable
// - codes 0..3 give 0..3, 4..7 give 7..10
// - each stretch cycle is four system clocks
// - stretch zero: two basic cycles, no stretch
// - stretch 1..3 adds 1..3 stretch cycles
// - first stretch adds one setup, one hold
// - slow stretch widens latch, setup, hold, strobe
// - strobe width scales with code and divider
// - stretch resets to one
// - divider code 10b means one system clock per oscillator
// - page miss when upper address byte changes
module emb_sequencer (
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [11:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    input wire logic REQ_I,
    input wire logic [1:0] REQ_KIND_I,
    input wire logic REQ_EXT_I,
    input wire logic [15:0] REQ_ADDR_I,
    input wire logic [7:0] REQ_WDATA_I,
    output logic BUSY_O,
    output logic DONE_O,
    output logic [7:0] RDATA_O,
    output logic ALE_O,
    output logic EXT_CODE_STROBE_N_O,
    output logic RD_N_O,
    output logic WR_N_O,
    output logic [15:0] ADDR_O,
    output logic [7:0] DATA_O,
    output logic DATA_OE_O,
    input wire logic [7:0] DATA_I
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        emb_pkg::emb_state_e state;
        logic [6:0] t;
        logic [6:0] total;
        logic [6:0] ale_end;
        logic [6:0] strb_start;
        logic [6:0] strb_end;
        logic [1:0] kind;
        logic ext;
        logic [7:0] csc;
        logic [3:0] cfg;
        logic [7:0] last_hi;
        logic hi_valid;
        logic force_miss;
        logic was_miss;
        logic ack;
        logic [15:0] wb_dat;
        logic busy;
        logic done;
        logic [7:0] rdata;
        logic ale;
        logic code_n;
        logic rd_n;
        logic wr_n;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic data_oe;
    } emb_seq_s;

    emb_seq_s r;
    emb_seq_s n;

    emb_tick_if tk ();

    emb_tick_div u_div (
        .clk_i(CLK_I),
        .rst_b_i(RST_B_I),
        .tk(tk.gen)
    );

    assign tk.div_sel = r.csc[emb_pkg::DIV_LSB +: 2];

    // ----------------------------------------------------------------
    // stretch decode
    // ----------------------------------------------------------------
    function automatic logic [3:0] stretch_cycles(input logic [2:0] code);
        logic [3:0] c;
        c = {1'b0, code};
        if (code[2])
            stretch_cycles = c + emb_pkg::SLOW_STRETCH_BASE;
        else
            stretch_cycles = c;
    endfunction

    // a page miss spends one whole hit cycle latching the upper byte first
    function automatic logic [6:0] page_clks(input logic is_miss, input logic [6:0] hit_clks);
        if (is_miss)
            page_clks = 7'(hit_clks << 1);
        else
            page_clks = hit_clks;
    endfunction

    logic tick;
    logic wb_hit;
    logic [7:0] idx;
    logic map_ok;
    logic [3:0] st;
    logic [6:0] st_clks;
    logic [6:0] h;
    logic page_en;
    logic [1:0] psel;
    logic miss;
    logic data_miss;
    logic strobe;
    logic running;

    always_comb
    begin
        n = r;
        tick = tk.tick;
        idx = ADR_I[9:2];
        map_ok = (ADR_I[11:10] == emb_pkg::ADR_TOP_ZERO);

        // ------------------------------------------------------------
        // stretch snapshot, applied only when an access is accepted
        // ------------------------------------------------------------
        st = stretch_cycles(r.csc[emb_pkg::STRETCH_LSB +: 3]);
        st_clks = {1'b0, st, 2'b00};

        // ------------------------------------------------------------
        // page decode
        // ------------------------------------------------------------
        page_en = r.cfg[emb_pkg::PAGE_EN_BIT];
        psel = r.cfg[emb_pkg::PAGE_SEL_LSB +: 2];
        h = (psel == emb_pkg::PAGE_SEL_ALT) ? 7'h02 : (7'h01 << psel);
        miss = !r.hi_valid || (REQ_ADDR_I[15:8] != r.last_hi) || r.force_miss;
        // in single-clock page mode every data move is a miss of its own
        data_miss = miss || (psel == 2'h0);
        strobe = 1'b0;
        running = 1'b0;

        // ------------------------------------------------------------
        // wishbone slave, one wait state, unmapped reads return zero
        // ------------------------------------------------------------
        // the ack term leaves a gap so a held strobe is not answered twice in a row
        wb_hit = CYC_I && STB_I && !r.ack;
        n.ack = wb_hit;
        if (wb_hit)
        begin
            n.wb_dat = 16'h0000;
            if (map_ok)
            begin
                case (idx)
                    emb_pkg::CSC_IDX:
                        n.wb_dat = {8'h00, r.csc};
                    emb_pkg::BUS_CFG_IDX:
                        n.wb_dat = {12'h000, r.cfg};
                    emb_pkg::STATUS_IDX:
                    begin
                        n.wb_dat[emb_pkg::ST_STRETCH_LSB +: 4] = st;
                        n.wb_dat[emb_pkg::ST_BUSY_BIT] = r.busy;
                        n.wb_dat[emb_pkg::ST_MISS_BIT] = r.was_miss;
                        n.wb_dat[emb_pkg::ST_VALID_BIT] = r.hi_valid;
                        n.wb_dat[emb_pkg::ST_HI_LSB +: 8] = r.last_hi;
                    end
                    default:
                        n.wb_dat = 16'h0000;
                endcase
            end
            if (WE_I && SEL_I[0] && map_ok)
            begin
                // a stretch or bus_config rewrite mid-access only touches the snapshot of the next one; the divider code acts at once
                if (idx == emb_pkg::CSC_IDX)
                    n.csc = DAT_I[7:0];
                else if (idx == emb_pkg::BUS_CFG_IDX)
                    n.cfg = DAT_I[3:0];
            end
        end

        // ------------------------------------------------------------
        // access sequencer
        // ------------------------------------------------------------
        n.done = 1'b0;
        case (r.state)
            emb_pkg::EMB_IDLE:
            begin
                if (REQ_I)
                begin
                    n.state = emb_pkg::EMB_RUN;
                    n.t = 7'h00;
                    n.busy = 1'b1;
                    n.kind = REQ_KIND_I;
                    n.ext = REQ_EXT_I;
                    n.addr = REQ_ADDR_I;
                    n.wdata = REQ_WDATA_I;
                    n.was_miss = 1'b0;
                    n.strb_start = 7'h00;
                    n.strb_end = 7'h00;
                    if (!REQ_EXT_I)
                    begin
                        n.total = emb_pkg::INT_CLKS;
                        n.ale_end = r.cfg[emb_pkg::ALE_INT_BIT] ? emb_pkg::ALE_CLKS : 7'h00;
                    end
                    else
                    begin
                        n.last_hi = REQ_ADDR_I[15:8];
                        n.hi_valid = 1'b1;
                        n.force_miss = 1'b0;
                        if (REQ_KIND_I == emb_pkg::KIND_CODE && !page_en)
                        begin
                            n.total = emb_pkg::CODE_CLKS;
                            n.ale_end = emb_pkg::ALE_CLKS;
                            n.strb_start = emb_pkg::CODE_STRB_START;
                            n.strb_end = emb_pkg::CODE_CLKS;
                        end
                        else if (REQ_KIND_I == emb_pkg::KIND_CODE)
                        begin
                            // miss: first half latches the upper byte, second half is a hit
                            n.was_miss = miss;
                            n.total = page_clks(miss, h);
                            n.ale_end = miss ? h : 7'h00;
                            n.strb_start = miss ? h : 7'h00;
                            n.strb_end = n.total;
                        end
                        else if (!page_en || psel == emb_pkg::PAGE_SEL_ALT)
                        begin
                            // two basic cycles, stretch cycles split over the phases
                            n.total = emb_pkg::DATA_CLKS + st_clks;
                            n.ale_end = emb_pkg::ALE_CLKS;
                            if (st == 4'h0)
                            begin
                                n.strb_start = emb_pkg::STRB0_START;
                                n.strb_end = emb_pkg::STRB0_END;
                            end
                            else if (st < emb_pkg::FIRST_SLOW_STRETCH)
                            begin
                                n.strb_start = emb_pkg::STRB1_START;
                                n.strb_end = emb_pkg::STRB1_START + st_clks;
                            end
                            else
                            begin
                                n.ale_end = emb_pkg::ALE_SLOW_CLKS;
                                n.strb_start = emb_pkg::STRB4_START;
                                n.strb_end = emb_pkg::STRB4_START + st_clks
                                    - {1'b0, emb_pkg::SLOW_STRETCH_BASE, 2'b00};
                            end
                        end
                        else
                        begin
                            // fast page data: page cycle plus whole stretch cycles
                            n.was_miss = data_miss;
                            n.total = page_clks(data_miss, h) + st_clks;
                            n.ale_end = data_miss ? h : 7'h00;
                            n.strb_start = data_miss ? h : 7'h00;
                            n.strb_end = n.total;
                            // single-clock page mode misses on and after every data move
                            n.force_miss = (psel == 2'h0);
                        end
                    end
                end
            end
            emb_pkg::EMB_RUN:
            begin
                if (tick)
                begin
                    // taken on the last strobe clock so a slow part gets the whole width
                    if (r.ext && r.kind == emb_pkg::KIND_RD && r.t == r.strb_end - 7'h01)
                        n.rdata = DATA_I;
                    if (r.t == r.total - 7'h01)
                    begin
                        n.state = emb_pkg::EMB_IDLE;
                        n.busy = 1'b0;
                        n.done = 1'b1;
                    end
                    else
                        n.t = r.t + 7'h01;
                end
            end
            default:
                n.state = emb_pkg::EMB_IDLE;
        endcase

        // ------------------------------------------------------------
        // pin levels, registered from the next phase position
        // ------------------------------------------------------------
        running = (n.state == emb_pkg::EMB_RUN);
        strobe = running && n.ext && n.t >= n.strb_start && n.t < n.strb_end;
        n.ale = running && n.t < n.ale_end;
        n.code_n = !(strobe && n.kind == emb_pkg::KIND_CODE);
        n.rd_n = !(strobe && n.kind == emb_pkg::KIND_RD);
        n.wr_n = !(strobe && n.kind == emb_pkg::KIND_WR);
        n.data_oe = running && n.ext && n.kind == emb_pkg::KIND_WR && n.t >= n.ale_end;
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            r <= '0;
            r.state <= emb_pkg::EMB_IDLE;
            r.csc <= emb_pkg::CSC_RESET;
            r.cfg <= emb_pkg::BUS_CFG_RESET;
            r.code_n <= 1'b1;
            r.rd_n <= 1'b1;
            r.wr_n <= 1'b1;
        end
        else
            r <= n;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign DAT_O = {16'h0000, r.wb_dat};
    assign ACK_O = r.ack;
    assign BUSY_O = r.busy;
    assign DONE_O = r.done;
    assign RDATA_O = r.rdata;
    assign ALE_O = r.ale;
    assign EXT_CODE_STROBE_N_O = r.code_n;
    assign RD_N_O = r.rd_n;
    assign WR_N_O = r.wr_n;
    assign ADDR_O = r.addr;
    assign DATA_O = r.wdata;
    assign DATA_OE_O = r.data_oe;

endmodule

//--- dv/emb_seq_assertions.sv
// concurrent checks on the sequencer top ports
`timescale 1ns/1ps
module emb_seq_chk (
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic ACK_O,
    input wire logic REQ_I,
    input wire logic REQ_EXT_I,
    input wire logic BUSY_O,
    input wire logic DONE_O,
    input wire logic ALE_O,
    input wire logic EXT_CODE_STROBE_N_O,
    input wire logic RD_N_O,
    input wire logic WR_N_O,
    input wire logic DATA_OE_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);

    sequence s_take;
        REQ_I && !BUSY_O;
    endsequence
    sequence s_rd_lo2;
        !RD_N_O ##1 !RD_N_O;
    endsequence

    wb_ack_a: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
        else $error("bus request not acknowledged");
    ack_pulse_a: assert property (ACK_O |=> !ACK_O)
        else $error("acknowledge held too long");
    take_busy_a: assert property (s_take |=> BUSY_O)
        else $error("access request not taken");
    int_fast_a: assert property (s_take ##0 !REQ_EXT_I |=> BUSY_O ##1 DONE_O)
        else $error("internal access not one clock");
    done_end_a: assert property (DONE_O |-> !BUSY_O && $past(BUSY_O))
        else $error("done without a running access");
    code_only_a: assert property (!EXT_CODE_STROBE_N_O |-> BUSY_O && RD_N_O && WR_N_O)
        else $error("code strobe outside a fetch");
    latch_quiet_a: assert property (ALE_O |-> EXT_CODE_STROBE_N_O && RD_N_O && WR_N_O)
        else $error("strobe active while latching");
    wr_drive_a: assert property (!WR_N_O |-> DATA_OE_O)
        else $error("write strobe without data drive");
    rd_float_a: assert property (!RD_N_O |-> !DATA_OE_O)
        else $error("data driven during read");
    rd_width_a: assert property ($fell(RD_N_O) |-> s_rd_lo2)
        else $error("read strobe shorter than two clocks");
    wr_width_a: assert property ($fell(WR_N_O) |=> !WR_N_O)
        else $error("write strobe shorter than two clocks");
endmodule

//--- dv/emb_ext_mem.sv
// far-side memory model for code and data cycles
`timescale 1ns/1ps
module emb_ext_mem (
    input wire logic clk_i,
    input wire logic [15:0] addr_i,
    input wire logic code_n_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o
);
    bit [7:0] mem [65536];

    initial data_o = 8'h00;

    // one clock of access time; a released bus toggles so a stale byte never passes
    always @(posedge clk_i)
    begin
        if (!wr_n_i)
            mem[addr_i] <= data_i;
        data_o <= (!rd_n_i || !code_n_i) ? mem[addr_i] : ~data_o;
    end
endmodule

//--- dv/tb_ext_memory_bus_stretch.sv
// self-checking bench for the external memory bus sequencer
`timescale 1ns/1ps
module tb_ext_memory_bus_stretch;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, req = 1'b0, req_ext = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat_w = 32'h0, dat_r, rv;
    logic [1:0] kind = 2'h0;
    logic [15:0] req_addr = 16'h0, addr, a;
    logic [7:0] wdata = 8'h0, rdata, data_o, data_i, h;
    logic ack, busy, done, ale, code_n, rd_n, wr_n, data_oe;
    int num_errors = 0, cmp_count = 0;
    int s_code = 1, page_en = 0, psel = 0;
    int model_mem [int];
    int stab [8] = '{0, 1, 2, 3, 7, 8, 9, 10};
    int wtab [8] = '{2, 4, 8, 12, 16, 20, 24, 28};

    always #2.5 clk = ~clk;

    emb_sequencer i_dut (.CLK_I(clk), .RST_B_I(rst_b), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
        .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack), .REQ_I(req), .REQ_KIND_I(kind),
        .REQ_EXT_I(req_ext), .REQ_ADDR_I(req_addr), .REQ_WDATA_I(wdata), .BUSY_O(busy), .DONE_O(done),
        .RDATA_O(rdata), .ALE_O(ale), .EXT_CODE_STROBE_N_O(code_n), .RD_N_O(rd_n), .WR_N_O(wr_n),
        .ADDR_O(addr), .DATA_O(data_o), .DATA_OE_O(data_oe), .DATA_I(data_i));
    emb_ext_mem i_mem (.clk_i(clk), .addr_i(addr), .code_n_i(code_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
        .data_i(data_o), .data_o(data_i));

    // ----------------------------------------------------------------
    // reporting and bus tasks
    // ----------------------------------------------------------------
    task stop_test;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task chk_n(input int got, input int exp, input string m);
        cmp_count++;
        if (got != exp)
        begin
            num_errors++;
            $display("CHECK FAILED %0t %s got %0d exp %0d", $time, m, got, exp);
        end
    endtask

    task chk_v(input logic [31:0] got, input logic [31:0] exp, input string m);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task wb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {2'h0, idx, 2'h0};
        sel <= 4'hf;
        dat_w <= {24'h0, wd};
        do
            @(posedge clk);
        while (ack !== 1'b1);
        rv = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    // en, ew, ea: expected length, strobe clocks, latch clocks; -1 skips, -2 on ea means latch seen at all
    task acc(input logic [1:0] k, input logic e, input logic [15:0] ad, input int en, input int ew, input int ea);
        int n;
        int w;
        int al;
        logic [7:0] wd;
        n = 0;
        w = 0;
        al = 0;
        wd = 8'($urandom);
        req <= 1'b1;
        kind <= k;
        req_ext <= e;
        req_addr <= ad;
        wdata <= wd;
        @(posedge clk);
        req <= 1'b0;
        do
        begin
            @(posedge clk);
            n++;
            w += int'(rd_n === 1'b0 || wr_n === 1'b0 || code_n === 1'b0);
            al += int'(ale === 1'b1);
        end
        while (done !== 1'b1 && n < 200);
        chk_v({31'h0, done}, 32'h1, "access end");
        if (en >= 0) chk_n(n - 1, en, "cycle length");
        if (ew >= 0) chk_n(w, ew, "strobe width");
        if (ea >= 0) chk_n(al, ea, "latch width");
        if (ea == -2) chk_n(int'(al > 0), 1, "latch seen");
        if (e && k == emb_pkg::KIND_WR) model_mem[ad] = wd;
        if (e && k == emb_pkg::KIND_RD && model_mem.exists(ad)) chk_v({24'h0, rdata}, model_mem[ad], "read data");
    endtask

    function int len(input int k, input int e, input int hit);
        int hc;
        hc = (psel == 3) ? 2 : (1 << psel);
        if (!e) return 1;
        if (k == 0) return !page_en ? 4 : (hit ? hc : 2 * hc);
        if (page_en && psel != 3) return (hit && psel != 0 ? hc : 2 * hc) + 4 * stab[s_code];
        return 8 + 4 * stab[s_code];
    endfunction

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        void'($urandom(15136));
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        wb(1'b0, emb_pkg::CSC_IDX, 8'h00);
        chk_v(rv, 32'h81, "control reset");
        wb(1'b0, emb_pkg::STATUS_IDX, 8'h00);
        chk_v(rv & 32'hf, 32'h1, "decoded stretch");
        wb(1'b0, 8'h12, 8'h00);
        chk_v(rv, 32'h0, "unmapped read");
        acc(emb_pkg::KIND_CODE, 1'b0, 16'h0010, 1, 0, 0);
        wb(1'b1, emb_pkg::BUS_CFG_IDX, 8'h08);
        acc(emb_pkg::KIND_CODE, 1'b0, 16'h0011, 1, 0, -2);
        acc(emb_pkg::KIND_CODE, 1'b1, 16'h1234, 4, 2, 1);
        wb(1'b1, emb_pkg::BUS_CFG_IDX, 8'h00);
        acc(emb_pkg::KIND_RD, 1'b0, 16'h0020, 1, 0, 0);
        for (int c = 0; c < 8; c++)
        begin
            s_code = c;
            wb(1'b1, emb_pkg::CSC_IDX, 8'h80 | 8'(c));
            wb(1'b0, emb_pkg::CSC_IDX, 8'h00);
            chk_v(rv, 32'h80 | c, "stretch readback");
            a = 16'($urandom);
            acc(emb_pkg::KIND_WR, 1'b1, a, len(2, 1, 0), wtab[c], c > 3 ? 5 : 1);
            acc(emb_pkg::KIND_RD, 1'b1, a, len(1, 1, 0), wtab[c], c > 3 ? 5 : 1);
        end
        // stretch rewritten while a read runs must wait for the next access
        wb(1'b1, emb_pkg::CSC_IDX, 8'h80);
        s_code = 0;
        fork
            acc(emb_pkg::KIND_RD, 1'b1, a, 8, 2, 1);
            begin
                repeat (3) @(posedge clk);
                wb(1'b1, emb_pkg::CSC_IDX, 8'h87);
            end
        join
        s_code = 7;
        acc(emb_pkg::KIND_RD, 1'b1, a, len(1, 1, 0), 28, 5);
        for (int p = 0; p < 4; p++)
        begin
            psel = p;
            page_en = 1;
            wb(1'b1, emb_pkg::BUS_CFG_IDX, 8'(2 * p + 1));
            h = 8'($urandom);
            acc(emb_pkg::KIND_CODE, 1'b1, {h, 8'h01}, -1, -1, -1);
            acc(emb_pkg::KIND_CODE, 1'b1, {h, 8'h02}, len(0, 1, 1), -1, 0);
            acc(emb_pkg::KIND_CODE, 1'b1, {~h, 8'h03}, len(0, 1, 0), -1, -2);
            acc(emb_pkg::KIND_WR, 1'b1, {~h, 8'h40}, len(2, 1, 1), -1, -1);
            acc(emb_pkg::KIND_RD, 1'b1, {~h, 8'h40}, len(1, 1, 1), -1, -1);
        end
        acc(emb_pkg::KIND_WR, 1'b1, a, len(2, 1, 0), 28, 5);
        stop_test();
    end

    // run needs a little over a thousand cycles; forty thousand leaves a wide margin
    initial
    begin
        #200000;
        num_errors++;
        stop_test();
    end
endmodule

bind emb_sequencer emb_seq_chk i_chk (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .CYC_I(CYC_I), .STB_I(STB_I),
    .ACK_O(ACK_O), .REQ_I(REQ_I), .REQ_EXT_I(REQ_EXT_I), .BUSY_O(BUSY_O), .DONE_O(DONE_O), .ALE_O(ALE_O),
    .EXT_CODE_STROBE_N_O(EXT_CODE_STROBE_N_O), .RD_N_O(RD_N_O), .WR_N_O(WR_N_O), .DATA_OE_O(DATA_OE_O));
